// File: include/pps_pkg.sv
package pps_pkg;
  // word index of each register, byte address is index times four
  localparam logic [5:0] IDX_CTRL  = 6'h30;  // status/control, shadow when extended
  localparam logic [5:0] IDX_EVT   = 6'h31;  // event flags, shadow when extended
  localparam logic [5:0] IDX_EN    = 6'h33;  // event enables (mask), shadow when extended
  localparam logic [5:0] IDX_EXT   = 6'h36;  // page select
  localparam logic [5:0] IDX_PSL   = 6'h37;  // accepted path signal label
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // status/control bits
  localparam int B_NEWPTR_EN  = 0;
  localparam int B_NEWPTR_EVT = 1;
  localparam int B_RDI        = 2;
  localparam int B_AIS        = 3;
  localparam int B_CAIS       = 4;
  localparam int B_LOP        = 5;
  localparam int B_LOPC       = 6;
  localparam int B_RSVD       = 7;
  // shadow status/control bits
  localparam int B_ERDI_MSB   = 2;
  localparam int B_LABEL_FILTER_FIVE       = 5;
  localparam int B_INV_OPT    = 6;
  // event flag bits, same layout for enables
  localparam int B_FEBE       = 0;
  localparam int B_BIP        = 1;
  localparam int B_RDI_CHG    = 2;
  localparam int B_AIS_CHG    = 3;
  localparam int B_LOP_CHG    = 5;
  localparam int B_PSL_CHG    = 7;
  localparam int B_ERDI_CHG   = 0;  // shadow event / shadow enable
  localparam int B_EXTEND     = 0;  // page select bit
  localparam logic [7:0] EVT_MASK = 8'hAF;  // implemented flag bits
  // label filter run lengths
  localparam logic [2:0] PSL_RUN_LONG  = 3'h5;
  localparam logic [2:0] PSL_RUN_SHORT = 3'h3;
  // bus sequencer states
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WR = 2'b10} pps_bus_e;
  // decoded register select
  typedef enum logic [3:0] {SEL_NONE = 4'h0, SEL_CTRL = 4'h1, SEL_CTRL_SH = 4'h2,
                            SEL_EVT = 4'h3, SEL_EVT_SH = 4'h4, SEL_EN = 4'h5,
                            SEL_EN_SH = 4'h6, SEL_EXT = 4'h7, SEL_PSL = 4'h8} pps_sel_e;
  // live alarm levels from the path processor
  typedef struct packed {
    logic       path_rdi_state;
    logic       aux_rdi_state;
    logic       path_ais_state;
    logic       concat_ais_state;
    logic       pointer_loss_state;
    logic       pointer_concat_loss_state;
    logic [2:0] enhanced_rdi_value;
  } pps_alarm_s;
  // one-cycle event pulses from the path processor
  typedef struct packed {
    logic new_pointer_event;
    logic far_block_error_event;
    logic path_parity_error_event;
    logic three_new_pointers;
  } pps_pulse_s;
endpackage

// File: verilog/pps_top.sv
// Notes on behaviour
// - enabled new pointer event raises interrupt
// - new pointer flag set, cleared by read
// - live path RDI and AIS bits
// - live concat AIS, LOP, LOP concat bits
// - extend bit selects shadow registers
// - shadow status shown at address C0 when extended
// - filtered enhanced RDI in shadow bits 2..0
// - option lets three pointers clear invalid count
// - label accepted after five or three repeats
// - far block error flag, clear on read
// - parity error flag, clear on read
// - RDI or aux RDI change flag
// - AIS change flag, clear on read
// - pointer loss change flag, clear on read
// - label change flag, clear on read
// - enabled events drive shared active-low interrupt
`timescale 1ns/1ns
module pps_top (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output      logic [31:0]          hrdata,
  output      logic                 hreadyout,
  output      logic                 hresp,
  input  wire pps_pkg::pps_alarm_s  alarm,
  input  wire pps_pkg::pps_pulse_s  pulses,
  input  wire logic [7:0]           c2_byte,
  input  wire logic                 c2_frame,
  input  wire logic                 other_irq_n,
  output      logic [7:0]           accepted_label,
  output      logic                 invalid_count_clear,
  output      logic                 interrupt_out_n
);

  pps_pkg::pps_bus_e   state_r;        // bus sequencer
  pps_pkg::pps_sel_e   wr_sel_r;       // register chosen by pending write
  pps_pkg::pps_sel_e   rd_sel;         // register chosen by current read
  pps_pkg::pps_alarm_s alarm_q_r;      // alarms one cycle ago
  logic [31:0]         hrdata_r;       // read data register
  logic [7:0]          rd_val;         // selected read value
  logic                take;           // address phase accepted
  logic                rd_take;        // read accepted this edge
  logic                wr_fire;        // write lands this edge
  logic                ext_r;          // shadow page select
  logic                newptr_en_r;    // new pointer interrupt enable
  logic                newptr_flag_r;  // new pointer sticky flag
  logic                ctrl_rsvd_r;    // reserved control bit
  logic [3:0]          sh_ctrl_r;      // shadow control bits 7..4
  logic [7:0]          evt_en_r;       // event enables
  logic                erdi_en_r;      // enhanced RDI change enable
  logic [7:0]          evt;            // events this cycle
  logic [7:0]          evt_clr;        // flags cleared this cycle
  logic [7:0]          evt_flag_r;     // sticky event flags
  logic                erdi_flag_r;    // enhanced RDI change flag
  logic [7:0]          cand_r;         // candidate label
  logic [2:0]          run_r;          // repeats of candidate
  logic [2:0]          run_need;       // repeats needed
  logic [7:0]          label_r;        // accepted label
  logic                label_load;     // candidate accepted now
  logic                label_chg;      // accepted label changes
  logic                inv_clr_r;      // invalid count clear pulse
  logic                irq;            // any unmasked flag

  // address decode, page chosen by the extend bit
  function automatic pps_pkg::pps_sel_e dec(input logic [31:0] a, input logic ext);
    logic [5:0] idx;
    idx = a[7:2];
    dec = pps_pkg::SEL_NONE;
    if (a[31:8] == 24'h000000) begin
      case (idx)
        pps_pkg::IDX_CTRL: dec = ext ? pps_pkg::SEL_CTRL_SH : pps_pkg::SEL_CTRL;
        pps_pkg::IDX_EVT:  dec = ext ? pps_pkg::SEL_EVT_SH : pps_pkg::SEL_EVT;
        pps_pkg::IDX_EN:   dec = ext ? pps_pkg::SEL_EN_SH : pps_pkg::SEL_EN;
        pps_pkg::IDX_EXT:  dec = pps_pkg::SEL_EXT;
        pps_pkg::IDX_PSL:  dec = pps_pkg::SEL_PSL;
        default:           dec = pps_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // bus handshake terms
  assign take      = hsel && (htrans == pps_pkg::HTRANS_NONSEQ) && hready;
  assign rd_take   = take && !hwrite;
  assign wr_fire   = (state_r == pps_pkg::ST_WR);
  assign rd_sel    = dec(haddr, ext_r);
  assign hreadyout = (state_r != pps_pkg::ST_WR);  // one wait state on writes
  assign hresp     = 1'b0;                          // always OKAY
  assign hrdata    = hrdata_r;

  // bus sequencer: writes take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= pps_pkg::ST_IDLE;
      wr_sel_r <= pps_pkg::SEL_NONE;
    end else begin
      case (state_r)
        pps_pkg::ST_IDLE: begin
          if (take && hwrite) begin
            state_r  <= pps_pkg::ST_WR;
            wr_sel_r <= rd_sel;
          end
        end
        pps_pkg::ST_WR: begin
          state_r <= pps_pkg::ST_IDLE;  // write lands, hready returns
        end
        default: state_r <= pps_pkg::ST_IDLE;
      endcase
    end
  end

  // read multiplexer, unmapped reads as zero
  always_comb begin
    case (rd_sel)
      pps_pkg::SEL_CTRL: rd_val = {ctrl_rsvd_r, alarm.pointer_concat_loss_state,
                                   alarm.pointer_loss_state, alarm.concat_ais_state,
                                   alarm.path_ais_state, alarm.path_rdi_state,
                                   newptr_flag_r, newptr_en_r};
      pps_pkg::SEL_CTRL_SH: rd_val = {sh_ctrl_r, 1'b0, alarm.enhanced_rdi_value};
      pps_pkg::SEL_EVT:     rd_val = evt_flag_r;
      pps_pkg::SEL_EVT_SH:  rd_val = {7'h00, erdi_flag_r};
      pps_pkg::SEL_EN:      rd_val = evt_en_r;
      pps_pkg::SEL_EN_SH:   rd_val = {7'h00, erdi_en_r};
      pps_pkg::SEL_EXT:     rd_val = {7'h00, ext_r};
      pps_pkg::SEL_PSL:     rd_val = label_r;
      default:              rd_val = 8'h00;
    endcase
  end

  // read data captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_r <= {24'h000000, rd_val};
    end
  end

  // software control bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_r       <= 1'b0;
      newptr_en_r <= 1'b0;
      ctrl_rsvd_r <= 1'b0;
      sh_ctrl_r   <= 4'h0;
      evt_en_r    <= 8'h00;
      erdi_en_r   <= 1'b0;
    end else if (wr_fire) begin
      case (wr_sel_r)
        pps_pkg::SEL_CTRL: begin
          newptr_en_r <= hwdata[pps_pkg::B_NEWPTR_EN];
          ctrl_rsvd_r <= hwdata[pps_pkg::B_RSVD];
        end
        pps_pkg::SEL_CTRL_SH: sh_ctrl_r <= hwdata[7:4];
        pps_pkg::SEL_EN:      evt_en_r  <= hwdata[7:0];
        pps_pkg::SEL_EN_SH:   erdi_en_r <= hwdata[pps_pkg::B_ERDI_CHG];
        pps_pkg::SEL_EXT:     ext_r     <= hwdata[pps_pkg::B_EXTEND];
        default: ;
      endcase
    end
  end

  // alarm history for change detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q_r <= '0;
    end else begin
      alarm_q_r <= alarm;
    end
  end

  // events of this cycle in flag layout
  always_comb begin
    evt = 8'h00;
    evt[pps_pkg::B_FEBE]    = pulses.far_block_error_event;
    evt[pps_pkg::B_BIP]     = pulses.path_parity_error_event;
    evt[pps_pkg::B_RDI_CHG] = (alarm.path_rdi_state != alarm_q_r.path_rdi_state) ||
                              (alarm.aux_rdi_state != alarm_q_r.aux_rdi_state);
    evt[pps_pkg::B_AIS_CHG] = alarm.path_ais_state != alarm_q_r.path_ais_state;
    evt[pps_pkg::B_LOP_CHG] = alarm.pointer_loss_state !=
                              alarm_q_r.pointer_loss_state;
    evt[pps_pkg::B_PSL_CHG] = label_chg;
  end

  // clear by read of the flag page, or write one to clear
  always_comb begin
    evt_clr = 8'h00;
    if (rd_take && rd_sel == pps_pkg::SEL_EVT) begin
      evt_clr = pps_pkg::EVT_MASK;
    end else if (wr_fire && wr_sel_r == pps_pkg::SEL_EVT) begin
      evt_clr = hwdata[7:0];
    end
  end

  // sticky flags, a new event outweighs the clear
  for (genvar i = 0; i < 8; i++) begin : g_evt
    if (pps_pkg::EVT_MASK[i]) begin : g_on
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          evt_flag_r[i] <= 1'b0;
        end else begin
          evt_flag_r[i] <= evt[i] | (evt_flag_r[i] & ~evt_clr[i]);
        end
      end
    end else begin : g_off
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          evt_flag_r[i] <= 1'b0;
        end else begin
          evt_flag_r[i] <= 1'b0;  // unused bit
        end
      end
    end
  end

  // new pointer flag, cleared by reading status/control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      newptr_flag_r <= 1'b0;
    end else if (pulses.new_pointer_event) begin
      newptr_flag_r <= 1'b1;
    end else if (rd_take && rd_sel == pps_pkg::SEL_CTRL) begin
      newptr_flag_r <= 1'b0;
    end
  end

  // enhanced RDI change flag on the shadow page
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      erdi_flag_r <= 1'b0;
    end else if (alarm.enhanced_rdi_value != alarm_q_r.enhanced_rdi_value) begin
      erdi_flag_r <= 1'b1;
    end else if ((rd_take && rd_sel == pps_pkg::SEL_EVT_SH) ||
                 (wr_fire && wr_sel_r == pps_pkg::SEL_EVT_SH &&
                  hwdata[pps_pkg::B_ERDI_CHG])) begin
      erdi_flag_r <= 1'b0;
    end
  end

  // label filter: a value must repeat before acceptance
  assign run_need   = sh_ctrl_r[pps_pkg::B_LABEL_FILTER_FIVE - 4] ? pps_pkg::PSL_RUN_LONG
                                                     : pps_pkg::PSL_RUN_SHORT;
  assign label_load = c2_frame && (c2_byte == cand_r) &&
                      (run_r == run_need - 3'h1);
  assign label_chg  = label_load && (cand_r != label_r);

  // candidate and run counter, saturates at the long run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_r <= 8'h00;
      run_r  <= 3'h0;
    end else if (c2_frame) begin
      if (c2_byte == cand_r) begin
        if (run_r != pps_pkg::PSL_RUN_LONG) begin
          run_r <= run_r + 3'h1;
        end
      end else begin
        cand_r <= c2_byte;
        run_r  <= 3'h1;
      end
    end
  end

  // accepted label
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      label_r <= 8'h00;
    end else if (label_load) begin
      label_r <= cand_r;
    end
  end
  assign accepted_label = label_r;

  // invalid pointer count clear while pointer is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inv_clr_r <= 1'b0;
    end else begin
      inv_clr_r <= sh_ctrl_r[pps_pkg::B_INV_OPT - 4] && alarm.pointer_loss_state &&
                   pulses.three_new_pointers;
    end
  end
  assign invalid_count_clear = inv_clr_r;

  // interrupt: unmasked flags pull the shared line low
  assign irq = (newptr_flag_r && newptr_en_r) ||
               (|(evt_flag_r & evt_en_r)) ||
               (erdi_flag_r && erdi_en_r);
  assign interrupt_out_n = other_irq_n && !irq;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_of(pps_pkg::pps_sel_e s);
    rd_take && rd_sel == s;
  endsequence

  property p_newptr_set;
    pulses.new_pointer_event |=> newptr_flag_r ##0 !interrupt_out_n || !newptr_en_r;
  endproperty
  a_newptr_set: assert property (p_newptr_set) else $error("new pointer flag lost");

  property p_newptr_irq;
    newptr_flag_r && newptr_en_r |-> !interrupt_out_n;
  endproperty
  a_newptr_irq: assert property (p_newptr_irq) else $error("no new pointer irq");

  property p_ctrl_live;
    s_rd_of(pps_pkg::SEL_CTRL) |=>
      hrdata[pps_pkg::B_LOP] == $past(alarm.pointer_loss_state) &&
      hrdata[pps_pkg::B_AIS] == $past(alarm.path_ais_state);
  endproperty
  a_ctrl_live: assert property (p_ctrl_live) else $error("status bits wrong");

  property p_shadow_read;
    s_rd_of(pps_pkg::SEL_CTRL_SH) |=>
      hrdata[pps_pkg::B_ERDI_MSB:0] == $past(alarm.enhanced_rdi_value);
  endproperty
  a_shadow_read: assert property (p_shadow_read) else $error("shadow status wrong");

  property p_ext_decode;
    rd_take && haddr[31:2] == {24'h000000, pps_pkg::IDX_CTRL} && ext_r
      |-> rd_sel == pps_pkg::SEL_CTRL_SH;
  endproperty
  a_ext_decode: assert property (p_ext_decode) else $error("extend decode wrong");

  property p_set_wins;
    s_rd_of(pps_pkg::SEL_EVT) ##0 evt[pps_pkg::B_FEBE] |=> evt_flag_r[pps_pkg::B_FEBE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  property p_cor;
    s_rd_of(pps_pkg::SEL_EVT) ##0 evt == 8'h00 |=> evt_flag_r == 8'h00;
  endproperty
  a_cor: assert property (p_cor) else $error("flags not cleared");

  property p_lop_chg;
    $changed(alarm.pointer_loss_state) |=> evt_flag_r[pps_pkg::B_LOP_CHG];
  endproperty
  a_lop_chg: assert property (p_lop_chg) else $error("lop change missed");

  property p_ais_chg;
    $changed(alarm.path_ais_state) |=> evt_flag_r[pps_pkg::B_AIS_CHG];
  endproperty
  a_ais_chg: assert property (p_ais_chg) else $error("ais change missed");

  property p_label;
    $changed(label_r) |-> $past(c2_frame) && label_r == $past(c2_byte) &&
                          $past(run_r) == $past(run_need) - 3'h1;
  endproperty
  a_label: assert property (p_label) else $error("label taken early");

  property p_inv;
    ##1 invalid_count_clear == ($past(sh_ctrl_r[pps_pkg::B_INV_OPT - 4]) &&
                                $past(alarm.pointer_loss_state) &&
                                $past(pulses.three_new_pointers));
  endproperty
  a_inv: assert property (p_inv) else $error("invalid count clear wrong");

  property p_wr_wait;
    take && hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");

endmodule

// File: dv/path_overhead_status_irq_tb_top.sv
`timescale 1ns/1ns
// compare helper, counts every check and reports mismatches
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module path_overhead_status_irq_tb_top;
  logic                hclk;                 // 20 MHz bus clock
  logic                hresetn;              // async reset, low active
  logic                hsel;                 // slave select
  logic [31:0]         haddr;                // byte address
  logic [1:0]          htrans;               // transfer type
  logic                hwrite;               // write strobe
  logic [31:0]         hwdata;               // write data
  logic [31:0]         hrdata;               // read data
  logic                hreadyout;            // slave ready, fed back as hready
  logic                hresp;                // response
  pps_pkg::pps_alarm_s alarm;                // live alarm levels
  pps_pkg::pps_pulse_s pulses;               // event pulses
  logic [7:0]          c2_byte;              // received label byte
  logic                c2_frame;             // frame strobe
  logic                other_irq_n;          // shared interrupt sources
  logic [7:0]          accepted_label;       // filtered label
  logic                invalid_count_clear;  // count reset pulse
  logic                interrupt_out_n;      // shared interrupt output
  logic [7:0]          exq[$];               // expected read data notes
  logic [7:0]          exp_b;                // oldest note, popped once
  logic                rd_ph;                // read data phase pending
  int                  bad_count;            // mismatches
  int                  cmp_count;            // comparisons
  int                  clr_cnt;              // count reset pulses seen
  integer              seed;                 // random seed
  logic [31:0]         rnd;                  // random word
  pps_top u_dut (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (3'h2),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .alarm               (alarm),
    .pulses              (pulses),
    .c2_byte             (c2_byte),
    .c2_frame            (c2_frame),
    .other_irq_n         (other_irq_n),
    .accepted_label      (accepted_label),
    .invalid_count_clear (invalid_count_clear),
    .interrupt_out_n     (interrupt_out_n)
  );
  // clock generator
  always #25 hclk = ~hclk;
  // verdict and end of run
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // output watcher: pops the oldest note when read data is due
  always @(posedge hclk) begin
    if (invalid_count_clear === 1'b1) begin
      clr_cnt++;
    end
    if (hreadyout === 1'b1) begin
      if (rd_ph) begin
        exp_b = exq.pop_front();
        `CHK(hrdata, {24'h000000, exp_b})
        `CHK(hresp, 1'b0)
      end
      rd_ph = hsel && htrans == pps_pkg::HTRANS_NONSEQ && !hwrite;
    end
  end
  // bounded wait for the slave to be ready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
  endtask
  // one single transfer, optional event pulse beside the address phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [7:0] e, input pps_pkg::pps_pulse_s pp);
    @(posedge hclk);
    if (!w) begin
      exq.push_back(e);
    end
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= pps_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    pulses <= pp;
    wait_rdy();
    pulses <= '0;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 8'h00, '0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000, e, '0);
  endtask
  // one-cycle event pulse
  task automatic pulse(input pps_pkg::pps_pulse_s p);
    @(posedge hclk);
    pulses <= p;
    @(posedge hclk);
    pulses <= '0;
  endtask
  // received label byte, repeated over k frames
  task automatic frame(input logic [7:0] b, input int k);
    repeat (k) begin
      @(posedge hclk);
      c2_byte  <= b;
      c2_frame <= 1'b1;
      @(posedge hclk);
      c2_frame <= 1'b0;
    end
  endtask
  // interrupt level check once flags have settled
  task automatic ci(input logic e);
    #1;
    `CHK(interrupt_out_n, e)
  endtask
  // main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = '0; alarm = '0; pulses = '0; c2_byte = 8'h00;
    c2_frame = 1'b0; other_irq_n = 1'b1; rd_ph = 1'b0; bad_count = 0;
    cmp_count = 0; clr_cnt = 0; seed = 49425;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ci(1'b1);
    rd(32'hC0, 8'h00);
    wr(32'hC0, 32'h81);
    rd(32'hC0, 8'h81);
    wr(32'hC0, 32'h01);
    pulse(4'h8);
    ci(1'b0);
    rd(32'hC0, 8'h03);
    rd(32'hC0, 8'h01);
    ci(1'b1);
    // live alarm levels, change flags masked
    @(posedge hclk);
    alarm <= 9'h178;
    rd(32'hC0, 8'h7D);
    ci(1'b1);
    rd(32'hC4, 8'h2C);
    rd(32'hC4, 8'h00);
    @(posedge hclk);
    alarm.aux_rdi_state <= 1'b1;
    rd(32'hC4, 8'h04);
    pulse(4'h6);
    rd(32'hC4, 8'h03);
    // event at the same edge as the clearing read
    bus(1'b0, 32'hC4, 32'h0, 8'h00, 4'h4);
    rd(32'hC4, 8'h01);
    wr(32'hCC, 32'h01);
    pulse(4'h4);
    ci(1'b0);
    rd(32'hC4, 8'h01);
    ci(1'b1);
    @(posedge hclk);
    other_irq_n <= 1'b0;
    ci(1'b0);
    @(posedge hclk);
    other_irq_n <= 1'b1;
    // write one to clear only the chosen flag
    pulse(4'h6);
    wr(32'hC4, 32'h01);
    rd(32'hC4, 8'h02);
    // random enable patterns, unmapped places
    repeat (4) begin
      rnd = $random(seed);
      wr(32'hCC, rnd);
      rd(32'hCC, rnd[7:0]);
    end
    wr(32'hCC, 32'h00);
    wr(32'h100, 32'hFF);
    rd(32'h100, 8'h00);
    rd(32'hC8, 8'h00);
    // shadow page
    wr(32'hD8, 32'h01);
    rd(32'hD8, 8'h01);
    @(posedge hclk);
    alarm.enhanced_rdi_value <= 3'h5;
    rd(32'hC0, 8'h05);
    rd(32'hC4, 8'h01);
    wr(32'hC0, 32'h40);
    rd(32'hC0, 8'h45);
    // enhanced RDI change through the shadow enable
    wr(32'hCC, 32'h01);
    rd(32'hCC, 8'h01);
    @(posedge hclk);
    alarm.enhanced_rdi_value <= 3'h2;
    @(posedge hclk);
    ci(1'b0);
    rd(32'hC4, 8'h01);
    ci(1'b1);
    wr(32'hCC, 32'h00);
    pulse(4'h1);
    repeat (2) @(posedge hclk);
    `CHK(clr_cnt, 1)
    wr(32'hC0, 32'h20);
    pulse(4'h1);
    repeat (2) @(posedge hclk);
    `CHK(clr_cnt, 1)
    // label filter, five then three repeats
    frame(8'hA5, 4);
    rd(32'hDC, 8'h00);
    frame(8'hA5, 1);
    rd(32'hDC, 8'hA5);
    `CHK(accepted_label, 8'hA5)
    wr(32'hC0, 32'h00);
    frame(8'h3C, 2);
    rd(32'hDC, 8'hA5);
    frame(8'h3C, 1);
    rd(32'hDC, 8'h3C);
    wr(32'hD8, 32'h00);
    rd(32'hC4, 8'h80);
    rd(32'hC4, 8'h00);
    @(posedge hclk);
    `CHK(exq.size() == 0, 1'b1)
    summarize();
  end
endmodule
